// File: hdl/iap_defines.svh
`ifndef IAP_DEFINES_SVH
`define IAP_DEFINES_SVH

// ----------------------------------------
// register indexes, byte address = 4 * index
// ----------------------------------------
`define IAP_IDX_KEY      8'hf1
`define IAP_IDX_ADDR_LO  8'hf2
`define IAP_IDX_ADDR_HI  8'hf3
`define IAP_IDX_AREA     8'hf4
`define IAP_IDX_DATA     8'hf5
`define IAP_IDX_CTRL     8'hf6
`define IAP_IDX_STATUS   8'hf7
`define IAP_IDX_OPTION   8'hf8

// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define IAP_RST_BYTE     8'h00
`define IAP_CTRL_CMD_LSB 0
`define IAP_CTRL_HLD_LSB 2
`define IAP_CMD_WRITE    2'h2
`define IAP_HI_ADDR_MSB  5
`define IAP_RANGE_HALF   14'h3e00
`define IAP_RANGE_ONE    14'h3c00
`define IAP_RESP_OKAY    2'h0
`define IAP_RESP_SLVERR  2'h2

// ----------------------------------------
// timing
// ----------------------------------------
`define IAP_CLK_HZ       50000000
`define IAP_HOLD_4MS_US  4000
`define IAP_HOLD_2MS_US  2000
`define IAP_HOLD_1MS_US  1000

`endif

// File: hdl/iap_pkg.sv
package iap_pkg;

  typedef enum logic [1:0] {
    IAP_ST_IDLE   = 2'b00,
    IAP_ST_STROBE = 2'b01,
    IAP_ST_HOLD   = 2'b11
  } iap_state_e;

  typedef enum logic [7:0] {
    IAP_AREA_CODE = 8'h00,
    IAP_AREA_ID   = 8'h01,
    IAP_AREA_EE   = 8'h02
  } iap_area_e;

  typedef enum logic [1:0] {
    IAP_HOLD_4MS = 2'b00,
    IAP_HOLD_2MS = 2'b01,
    IAP_HOLD_1MS = 2'b10,
    IAP_HOLD_RSV = 2'b11
  } iap_hold_e;

  typedef enum logic [1:0] {
    IAP_OPT_NONE = 2'b00,
    IAP_OPT_HALF = 2'b01,
    IAP_OPT_ONE  = 2'b10,
    IAP_OPT_ALL  = 2'b11
  } iap_opt_e;

  typedef struct packed {
    logic [1:0]  area;
    logic [13:0] addr;
    logic [7:0]  data;
  } iap_mem_wr_s;

endpackage

// File: hdl/iap_write_ctrl.sv
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/100ps
`include "iap_defines.svh"

module iap_write_ctrl
  import iap_pkg::*;
#(
  parameter int          INT_ID_W     = 3,
  parameter int          HOLD_CNT_W   = 18,
  parameter int unsigned HOLD_4MS_CYC = `IAP_HOLD_4MS_US * (`IAP_CLK_HZ / 1000000),
  parameter int unsigned HOLD_2MS_CYC = `IAP_HOLD_2MS_US * (`IAP_CLK_HZ / 1000000),
  parameter int unsigned HOLD_1MS_CYC = `IAP_HOLD_1MS_US * (`IAP_CLK_HZ / 1000000)
) (
  // clock and reset
  input  wire logic                sys_clk,
  input  wire logic                resetn,
  // axi4-lite write
  input  wire logic [11:0]         s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  // axi4-lite read
  input  wire logic [11:0]         s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  // memory array side
  output iap_mem_wr_s              memWr,
  output logic                     memWrStrobe,
  output logic [1:0]               tableReadMap,
  // processor side
  output logic                     pcStall,
  input  wire logic                intEvent,
  input  wire logic [INT_ID_W-1:0] intEventId,
  output logic                     intTake,
  output logic [INT_ID_W-1:0]      intTakeId
);

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [7:0]            keyCnt_r;
  logic [7:0]            addrLo_r;
  logic [5:0]            addrHi_r;
  logic [7:0]            area_r;
  logic [7:0]            data_r;
  logic [1:0]            hold_r;
  logic [1:0]            cmd_r;
  logic [1:0]            option_r;
  logic                  refused_r;
  iap_state_e            state_r;
  logic [HOLD_CNT_W-1:0] holdCnt_r;
  iap_mem_wr_s           memWr_r;
  logic                  intPend_r;
  logic [INT_ID_W-1:0]   intPendId_r;
  logic                  intTake_r;
  logic [INT_ID_W-1:0]   intTakeId_r;

  // axi holding state
  logic        awHeld_r;
  logic [11:0] awAddr_r;
  logic        wHeld_r;
  logic [31:0] wData_r;
  logic [3:0]  wStrb_r;
  logic        bvalid_r;
  logic [1:0]  bresp_r;
  logic        rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0]  rresp_r;

  // ----------------------------------------
  // decode helpers
  // ----------------------------------------
  function automatic logic isMapped(input logic [11:0] addr);
    isMapped = (addr[11:10] == 2'b00) && (addr[9:2] >= `IAP_IDX_KEY) && (addr[9:2] <= `IAP_IDX_OPTION);
  endfunction

  function automatic logic [HOLD_CNT_W-1:0] holdLen(input logic [1:0] code);
    unique case (code)
      IAP_HOLD_4MS: holdLen = HOLD_CNT_W'(HOLD_4MS_CYC);
      IAP_HOLD_2MS: holdLen = HOLD_CNT_W'(HOLD_2MS_CYC);
      IAP_HOLD_1MS: holdLen = HOLD_CNT_W'(HOLD_1MS_CYC);
      default:      holdLen = HOLD_CNT_W'(HOLD_1MS_CYC);
    endcase
  endfunction

  logic [13:0] targetAddr;
  logic        doWrite;
  logic        lane0;
  logic [7:0]  wrIdx;
  logic [7:0]  wrByte;
  logic        ctrlWrite;
  logic        cmdGo;
  logic        unlocked;
  logic        areaWritable;
  logic        accept;
  logic        holdEnd;

  assign targetAddr = {addrHi_r, addrLo_r};
  assign doWrite    = awHeld_r && wHeld_r && !bvalid_r;
  assign lane0      = wStrb_r[0];
  assign wrIdx      = awAddr_r[9:2];
  assign wrByte     = wData_r[7:0];
  assign unlocked   = (keyCnt_r != 8'h00);

  // code range per option, ID area never written
  always_comb begin
    unique case (area_r)
      IAP_AREA_CODE: begin
        unique case (option_r)
          IAP_OPT_NONE: areaWritable = 1'b0;
          IAP_OPT_HALF: areaWritable = (targetAddr >= `IAP_RANGE_HALF);
          IAP_OPT_ONE:  areaWritable = (targetAddr >= `IAP_RANGE_ONE);
          default:      areaWritable = 1'b1;
        endcase
      end
      IAP_AREA_EE: areaWritable = 1'b1;
      default:     areaWritable = 1'b0;
    endcase
  end

  assign ctrlWrite = doWrite && lane0 && isMapped(awAddr_r) && (wrIdx == `IAP_IDX_CTRL) && (state_r == IAP_ST_IDLE);
  assign cmdGo     = ctrlWrite && (wrByte[`IAP_CTRL_CMD_LSB +: 2] == `IAP_CMD_WRITE);
  assign accept    = cmdGo && unlocked && areaWritable
                     && (wrByte[`IAP_CTRL_HLD_LSB +: 2] != IAP_HOLD_RSV);
  assign holdEnd   = (state_r == IAP_ST_HOLD) && (holdCnt_r == '0);

  // ----------------------------------------
  // axi write channel
  // ----------------------------------------
  assign s_axi_awready = !awHeld_r && !bvalid_r;
  assign s_axi_wready  = !wHeld_r && !bvalid_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      awHeld_r <= 1'b0;
      awAddr_r <= 12'h000;
      wHeld_r  <= 1'b0;
      wData_r  <= 32'h0000_0000;
      wStrb_r  <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r  <= `IAP_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_r <= 1'b1;
        awAddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_r <= 1'b1;
        wData_r <= s_axi_wdata;
        wStrb_r <= s_axi_wstrb;
      end
      if (doWrite) begin
        awHeld_r <= 1'b0;
        wHeld_r  <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r  <= isMapped(awAddr_r) ? `IAP_RESP_OKAY : `IAP_RESP_SLVERR;
      end else if (bvalid_r && s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // axi read channel
  // ----------------------------------------
  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;

  logic [7:0] rdByte;

  always_comb begin
    unique case (s_axi_araddr[9:2])
      `IAP_IDX_KEY:     rdByte = keyCnt_r;
      `IAP_IDX_ADDR_LO: rdByte = addrLo_r;
      `IAP_IDX_ADDR_HI: rdByte = {2'b00, addrHi_r};
      `IAP_IDX_AREA:    rdByte = area_r;
      `IAP_IDX_DATA:    rdByte = data_r;
      `IAP_IDX_CTRL:    rdByte = {4'h0, hold_r, cmd_r};
      `IAP_IDX_STATUS:  rdByte = {5'h00, refused_r, unlocked, pcStall};
      `IAP_IDX_OPTION:  rdByte = {6'h00, option_r};
      default:          rdByte = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      rresp_r  <= `IAP_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_r <= 1'b1;
      rdata_r  <= isMapped(s_axi_araddr) ? {24'h000000, rdByte} : 32'h0000_0000;
      rresp_r  <= isMapped(s_axi_araddr) ? `IAP_RESP_OKAY : `IAP_RESP_SLVERR;
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // ----------------------------------------
  // plain setup registers
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      addrLo_r <= `IAP_RST_BYTE;
      addrHi_r <= 6'h00;
      area_r   <= `IAP_RST_BYTE;
      data_r   <= `IAP_RST_BYTE;
      option_r <= 2'b00;
    end else if (doWrite && lane0) begin
      unique case (wrIdx)
        `IAP_IDX_ADDR_LO: addrLo_r <= wrByte;
        `IAP_IDX_ADDR_HI: addrHi_r <= wrByte[`IAP_HI_ADDR_MSB:0];
        `IAP_IDX_AREA:    area_r   <= wrByte;
        `IAP_IDX_DATA:    data_r   <= wrByte;
        `IAP_IDX_OPTION:  option_r <= wrByte[1:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // unlock window
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      keyCnt_r <= `IAP_RST_BYTE;
    end else if (doWrite && lane0 && wrIdx == `IAP_IDX_KEY) begin
      keyCnt_r <= wrByte;
    end else if (accept) begin
      keyCnt_r <= 8'h00;
    end else if (unlocked) begin
      keyCnt_r <= keyCnt_r - 8'h01;
    end
  end

  // ----------------------------------------
  // control register and refusal status
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      hold_r    <= 2'b00;
      cmd_r     <= 2'b00;
      refused_r <= 1'b0;
    end else if (ctrlWrite) begin
      hold_r    <= wrByte[`IAP_CTRL_HLD_LSB +: 2];
      cmd_r     <= accept ? `IAP_CMD_WRITE : 2'b00;
      refused_r <= cmdGo && !accept;
    end else if (holdEnd) begin
      cmd_r <= 2'b00;
    end
  end

  // ----------------------------------------
  // write sequencer and processor hold
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      state_r   <= IAP_ST_IDLE;
      holdCnt_r <= '0;
      memWr_r   <= '0;
    end else begin
      unique case (state_r)
        IAP_ST_IDLE: begin
          if (accept) begin
            state_r      <= IAP_ST_STROBE;
            memWr_r.area <= area_r[1:0];
            memWr_r.addr <= targetAddr;
            memWr_r.data <= data_r;
          end
        end
        IAP_ST_STROBE: begin
          state_r   <= IAP_ST_HOLD;
          holdCnt_r <= holdLen(hold_r) - HOLD_CNT_W'(2);
        end
        IAP_ST_HOLD: begin
          if (holdEnd) begin
            state_r <= IAP_ST_IDLE;
          end else begin
            holdCnt_r <= holdCnt_r - HOLD_CNT_W'(1);
          end
        end
        default: state_r <= IAP_ST_IDLE;
      endcase
    end
  end

  assign memWr       = memWr_r;
  assign memWrStrobe = (state_r == IAP_ST_STROBE);
  assign pcStall     = (state_r != IAP_ST_IDLE);

  // table reads follow the area select, reserved values map to code
  always_comb begin
    unique case (area_r)
      IAP_AREA_ID: tableReadMap = 2'b01;
      IAP_AREA_EE: tableReadMap = 2'b10;
      default:     tableReadMap = 2'b00;
    endcase
  end

  // ----------------------------------------
  // interrupt retention across the hold
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      intPend_r   <= 1'b0;
      intPendId_r <= '0;
      intTake_r   <= 1'b0;
      intTakeId_r <= '0;
    end else if (pcStall && !holdEnd) begin
      intTake_r <= 1'b0;
      if (intEvent) begin
        intPend_r   <= 1'b1;
        intPendId_r <= intEventId;
      end
    end else begin
      intPend_r   <= 1'b0;
      intTake_r   <= intEvent || intPend_r;
      intTakeId_r <= intEvent ? intEventId : intPendId_r;
    end
  end

  assign intTake   = intTake_r;
  assign intTakeId = intTakeId_r;

endmodule

// File: verification/iap_write_ctrl_monitor.sv
`timescale 1ns/100ps

module iap_write_ctrl_monitor
  import iap_pkg::*;
#(
  parameter int          INT_ID_W     = 3,
  parameter int unsigned HOLD_4MS_CYC = 20
) (
  // clock and reset
  input wire logic                sys_clk,
  input wire logic                resetn,
  // bus
  input wire logic                s_axi_awready,
  input wire logic                s_axi_wready,
  input wire logic                s_axi_bvalid,
  input wire logic                s_axi_rvalid,
  input wire logic                s_axi_rready,
  // memory and processor
  input wire iap_mem_wr_s         memWr,
  input wire logic                memWrStrobe,
  input wire logic                pcStall,
  input wire logic                intEvent,
  input wire logic [INT_ID_W-1:0] intEventId,
  input wire logic                intTake,
  input wire logic [INT_ID_W-1:0] intTakeId
);
  localparam int HMAX = HOLD_4MS_CYC;

  default clocking mcb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  // ----------------------------------------
  // write sequence steps
  // ----------------------------------------
  sequence strobeStart;
    memWrStrobe && pcStall;
  endsequence
  sequence holdRest;
    (!memWrStrobe && pcStall) [*4];
  endsequence

  AST_STROBE_STALL: assert property (memWrStrobe |-> pcStall)
    else $error("strobe outside stall");
  AST_STROBE_START: assert property ($rose(pcStall) |-> strobeStart)
    else $error("stall without strobe");
  AST_STROBE_ONCE: assert property (strobeStart |=> holdRest)
    else $error("hold too short or strobe repeated");
  AST_HOLD_END: assert property ($rose(pcStall) |-> ##[5:HMAX] !pcStall)
    else $error("hold too long");
  AST_NO_ID_WRITE: assert property (memWrStrobe |-> memWr.area != 2'h1)
    else $error("write to id area");
  AST_INT_PASS: assert property (intEvent && !pcStall |=> intTake && intTakeId == $past(intEventId))
    else $error("interrupt not passed");
  AST_INT_HOLD: assert property (pcStall && !$rose(pcStall) |-> !intTake)
    else $error("interrupt taken in hold");
  AST_B_REFUSE: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during response");
  AST_R_ONE: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read response repeated");
endmodule

bind iap_write_ctrl iap_write_ctrl_monitor #(.INT_ID_W(INT_ID_W), .HOLD_4MS_CYC(HOLD_4MS_CYC)) iap_write_ctrl_monitor_i (
  .sys_clk(sys_clk), .resetn(resetn), .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .memWr(memWr),
  .memWrStrobe(memWrStrobe), .pcStall(pcStall), .intEvent(intEvent), .intEventId(intEventId),
  .intTake(intTake), .intTakeId(intTakeId));

// File: verification/iap_mem_model.sv
`timescale 1ns/100ps

module iap_mem_model
  import iap_pkg::*;
(
  // clock
  input wire logic  sys_clk,
  // write port
  input wire iap_mem_wr_s memWr,
  input wire logic  memWrStrobe,
  // bookkeeping
  output int        wrCount,
  output iap_mem_wr_s lastWr
);
  logic [7:0] cells [logic [15:0]];

  initial wrCount = 0;
  // array takes one byte per strobe
  always @(posedge sys_clk) begin
    if (memWrStrobe === 1'b1) begin
      cells[{memWr.area, memWr.addr}] = memWr.data;
      lastWr <= memWr;
      wrCount <= wrCount + 1;
    end
  end
endmodule

// File: verification/iap_write_ctrl_tb.sv
`timescale 1ns/100ps
`include "iap_defines.svh"

module iap_write_ctrl_tb
  import iap_pkg::*;
;
  logic        sys_clk, resetn, awvalid, wvalid, arvalid, intEvent, injectIrq, bready, rready;
  logic [3:0]  wstrb;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp, resp, tableReadMap;
  logic [2:0]  intEventId, intTakeId;
  logic [7:0]  rd;
  logic        awready, wready, bvalid, arready, rvalid, memWrStrobe, pcStall, intTake;
  iap_mem_wr_s memWr, lastWr;
  int          bad_count, comparisons, cycles, wrCount;
  logic [7:0]  optTab [5] = '{8'h01, 8'h01, 8'h02, 8'h02, 8'h03};
  logic [13:0] adTab  [5] = '{14'h3dff, 14'h3e00, 14'h3bff, 14'h3c00, 14'h0000};
  int          lenTab [5] = '{0, 5, 0, 5, 5};

  iap_write_ctrl #(.HOLD_4MS_CYC(20), .HOLD_2MS_CYC(10), .HOLD_1MS_CYC(5)) iap_write_ctrl_i (
    .sys_clk(sys_clk), .resetn(resetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .memWr(memWr),
    .memWrStrobe(memWrStrobe), .tableReadMap(tableReadMap), .pcStall(pcStall), .intEvent(intEvent),
    .intEventId(intEventId), .intTake(intTake), .intTakeId(intTakeId));

  iap_mem_model iap_mem_model_i (.sys_clk(sys_clk), .memWr(memWr), .memWrStrobe(memWrStrobe),
    .wrCount(wrCount), .lastWr(lastWr));

  // ----------------------------------------
  // bus and check tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    awaddr <= {2'h0, idx, 2'h0};
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    resp = bresp;
  endtask

  task automatic rdr(input logic [7:0] idx);
    araddr <= {2'h0, idx, 2'h0};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rd = rdata[7:0];
    resp = rresp;
  endtask

  // full programming sequence, measures stall length
  task automatic prog(input logic [7:0] area, input logic [13:0] addr, input logic [7:0] data,
                      input logic [7:0] key, input logic [7:0] ctl, input int expLen);
    int len;
    int n0;
    n0 = wrCount;
    wr(`IAP_IDX_AREA, area);
    wr(`IAP_IDX_DATA, data);
    wr(`IAP_IDX_ADDR_HI, {2'h0, addr[13:8]});
    wr(`IAP_IDX_ADDR_LO, addr[7:0]);
    wr(`IAP_IDX_KEY, key);
    wr(`IAP_IDX_CTRL, ctl);
    len = pcStall;
    while (pcStall === 1'b1 && len < 100) begin
      intEvent <= injectIrq && len < 3;
      intEventId <= (len == 1) ? 3'h3 : 3'h5;
      @(posedge sys_clk);
      len += pcStall;
    end
    chk("stallLength", len, expLen);
    chk("writeCount", wrCount - n0, expLen != 0);
    if (expLen != 0) chk("target", lastWr, {area[1:0], addr, data});
    if (injectIrq) chk("heldInterrupt", {intTake, intTakeId}, 4'hd);
    wr(`IAP_IDX_AREA, 8'h00);
  endtask

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      bad_count++;
      complete_run;
    end
  end

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    {resetn, awvalid, wvalid, arvalid, intEvent, injectIrq, bready, rready} = 8'h00;
    wstrb = 4'h1;
    {awaddr, araddr, wdata, intEventId} = '0;
    {bad_count, comparisons, cycles} = '0;
    repeat (20) @(posedge sys_clk);
    resetn <= 1'b1;
    for (int i = 'hf1; i <= 'hf8; i++) begin
      rdr(i[7:0]);
      chk("resetValue", rd, 8'h00);
    end
    rdr(8'h10);
    chk("unmappedResp", resp, `IAP_RESP_SLVERR);
    wr(`IAP_IDX_ADDR_HI, 8'hff);
    rdr(`IAP_IDX_ADDR_HI);
    chk("addrHigh", rd, 8'h3f);
    wr(`IAP_IDX_ADDR_LO, 8'ha5);
    rdr(`IAP_IDX_ADDR_LO);
    chk("addrLow", rd, 8'ha5);
    wstrb <= 4'h0;
    wr(`IAP_IDX_ADDR_LO, 8'h5a);
    wstrb <= 4'h1;
    chk("maskedResp", resp, `IAP_RESP_OKAY);
    rdr(`IAP_IDX_ADDR_LO);
    chk("maskedWrite", rd, 8'ha5);
    resetn <= 1'b0;
    repeat (2) @(posedge sys_clk);
    resetn <= 1'b1;
    rdr(`IAP_IDX_ADDR_LO);
    chk("addrLowReset", rd, 8'h00);
    for (int a = 0; a < 4; a++) begin
      wr(`IAP_IDX_AREA, a[7:0]);
      chk("tableMap", tableReadMap, (a == 3) ? 2'h0 : a[1:0]);
    end
    for (int h = 0; h < 3; h++) begin
      prog(8'h02, 14'h0040 + h, 8'h30 + h, 8'hf0, {4'h0, h[1:0], 2'h2}, 20 >> h);
    end
    prog(8'h02, 14'h0011, 8'h77, 8'hf0, 8'h0e, 0);
    rdr(`IAP_IDX_STATUS);
    chk("refusedFlag", rd & 8'h04, 8'h04);
    rdr(`IAP_IDX_CTRL);
    chk("cmdCleared", rd & 8'h03, 8'h00);
    prog(8'h01, 14'h0012, 8'h78, 8'hf0, 8'h0a, 0);
    for (int c = 0; c < 4; c = c + 1 + (c == 1)) begin
      prog(8'h02, 14'h0013, 8'h79, 8'hf0, {6'h2, c[1:0]}, 0);
    end
    prog(8'h02, 14'h0014, 8'h7a, 8'h00, 8'h0a, 0);
    prog(8'h02, 14'h0015, 8'h7b, 8'h01, 8'h0a, 0);
    prog(8'h02, 14'h0016, 8'h7c, 8'h02, 8'h0a, 0);
    prog(8'h02, 14'h0017, 8'h7e, 8'h03, 8'h0a, 5);
    prog(8'h00, 14'h3fff, 8'h7d, 8'hf0, 8'h0a, 0);
    for (int k = 0; k < 5; k++) begin
      wr(`IAP_IDX_OPTION, optTab[k]);
      prog(8'h00, adTab[k], 8'hc0 + k, 8'hf0, 8'h0a, lenTab[k]);
    end
    intEvent <= 1'b1;
    intEventId <= 3'h2;
    @(posedge sys_clk);
    intEvent <= 1'b0;
    @(posedge sys_clk);
    chk("passedInterrupt", {intTake, intTakeId}, 4'ha);
    injectIrq = 1'b1;
    prog(8'h02, 14'h007e, 8'h99, 8'hf0, 8'h02, 20);
    injectIrq = 1'b0;
    complete_run;
  end
endmodule
